// ===== hdl/flash_aux_pkg.sv
// Purpose: Shared constants and types for the block.
// Assumes: Single-bit serial command transfer, one byte per eight link clocks.
// Notes: Opcodes and byte values follow the command set.
package flash_aux_pkg;

  localparam logic [7:0] OPC_PERSIST_READ = 8'hfc;
  localparam logic [7:0] OPC_PERSIST_READ_4B = 8'he2;
  localparam logic [7:0] OPC_PERSIST_PROGRAM = 8'hfd;
  localparam logic [7:0] OPC_PERSIST_PROGRAM_4B = 8'he3;
  localparam logic [7:0] OPC_PERSIST_ERASE = 8'he4;
  localparam logic [7:0] OPC_DYNAMIC_READ = 8'hfa;
  localparam logic [7:0] OPC_DYNAMIC_READ_4B = 8'he0;
  localparam logic [7:0] OPC_DYNAMIC_WRITE = 8'hfb;
  localparam logic [7:0] OPC_DYNAMIC_WRITE_4B = 8'he1;
  localparam logic [7:0] OPC_PATTERN_PROGRAM = 8'h43;
  localparam logic [7:0] OPC_PATTERN_WRITE = 8'h4a;
  localparam logic [7:0] OPC_PATTERN_READ = 8'h41;
  localparam logic [7:0] OPC_SECURE_READ = 8'h4b;
  localparam logic [7:0] OPC_SECURE_PROGRAM = 8'h42;

  localparam logic [7:0] BYTE_UNPROTECTED = 8'hff;
  localparam logic [7:0] BYTE_PROTECTED = 8'h00;
  localparam logic [7:0] PATTERN_RESET = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  localparam logic [3:0] ADDR_BYTES_3 = 4'h3;
  localparam logic [3:0] ADDR_BYTES_4 = 4'h4;
  localparam logic [3:0] ADDR_BYTES_NONE = 4'h0;
  localparam logic [3:0] BYTE_COUNT_MAX = 4'hf;

  localparam int SECURE_BYTES = 1024;
  localparam int SECURE_ADDR_W = 10;
  localparam int REGION_BYTES = 32;
  localparam int REGION_COUNT = 32;
  localparam int CHUNK_BYTES = 16;
  localparam int CHUNK_SHIFT = 4;
  localparam int CHUNK_COUNT = 64;
  localparam int RANDOM_BYTES = 16;
  localparam int DATA_LINES = 4;
  localparam logic [CHUNK_COUNT-1:0] CHUNK_FACTORY_PROGRAMMED = 64'h0000_0000_0000_0001;

  typedef enum logic [2:0] {
    OP_PERSIST_PROGRAM,
    OP_PERSIST_ERASE,
    OP_DYNAMIC_WRITE,
    OP_PATTERN_PROGRAM,
    OP_PATTERN_WRITE,
    OP_SECURE_PROGRAM,
    OP_SECURE_READ
  } op_kind_t;

endpackage

// ===== hdl/secure_region_mem.sv
// Purpose: Secure region storage with registered read data.
// Assumes: Programming only clears bits, as a flash cell does; there is no erase port.
// Notes: The lowest bytes come up holding the factory random value.
`timescale 1ns/1ns
module secure_region_mem #(
  parameter int DEPTH = 1024,
  parameter int ADDR_W = 10,
  parameter logic [127:0] FACTORY_RANDOM = 128'h5a3c_96e1_0f2d_7b48_c3a5_1e6f_d209_847b // Arbitrary value.
) (
  input wire logic clk_in, // Core clock.
  input wire logic prog_in, // Program strobe, one cycle.
  input wire logic [ADDR_W-1:0] prog_addr_in, // Byte to program.
  input wire logic [7:0] prog_data_in, // Bits at zero are programmed.
  input wire logic rd_in, // Read strobe, one cycle.
  input wire logic [ADDR_W-1:0] rd_addr_in, // Byte to read.
  output logic [7:0] rd_data_out // Read data, one cycle after the strobe.
);
  logic [7:0] cells [DEPTH];

  initial
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      cells[i] = (i < flash_aux_pkg::RANDOM_BYTES) ? FACTORY_RANDOM[8*i +: 8] : flash_aux_pkg::ERASED_BYTE;
    end
  end

  // A repeat program only clears further bits, so it is harmless.
  always_ff @(posedge clk_in)
  begin
    if (prog_in)
    begin
      cells[prog_addr_in] <= cells[prog_addr_in] & prog_data_in;
    end
    if (rd_in)
    begin
      rd_data_out <= cells[rd_addr_in];
    end
  end
endmodule

// ===== hdl/flash_protect_otp_training.sv
// Purpose: Per-sector protection arrays, training pattern registers and secure region access.
// Assumes: Frames arrive on the link clock; the read engine flags DDR dummy cycles in that domain.
// Notes: Stored arrays are read by the link domain as quiet words between frames.
//
// What this block does
// - Non-volatile protect bit per sector, all unprotected (ones) after power-on.
// - Non-volatile protect read returns 00h if protected, FFh otherwise.
// - Non-volatile protect opcodes: read FCh/E2h, program FDh/E3h, erase E4h.
// - Volatile protect opcodes: read FAh/E0h, write FBh/E1h, one sector each.
// - Volatile protect byte 00h means protected, FFh means unprotected.
// - Volatile protect bits reset to unprotected; no non-volatile backing.
// - Stored training pattern starts 00h, programs once, refuses later attempts.
// - Programming the stored pattern copies it into the live pattern.
// - Live pattern writable anytime; reloads from stored pattern on every reset.
// - Pattern opcodes: 43h program stored, 4Ah write live, 41h read.
// - In DDR dummy cycles drive live pattern on all lines, MSB first, per edge.
// - No preamble is driven when the live pattern is 00h.
// - Secure region is 1024 bytes, 32 regions of 32 bytes, with no per-region lock.
// - Secure read 4Bh follows fast read; out of range data is undefined.
// - Secure program 42h follows page program, repeatable, never erasable.
// - First program of a 16-byte chunk keeps ECC; a repeat disables it.
// - Out of range secure program is ignored without program error.
// - In range secure program while freeze is 1 fails with program error.
// - Protection mode selection never guards the secure region.
// - Lowest 16 secure bytes hold a factory 128-bit random value.
// - A rejected program raises the program error flag.
// - Non-volatile protect program or erase refused while array lock is 0.
// - A sector is protected when either of its two bits is 0.
`timescale 1ns/1ns
module flash_protect_otp_training #(
  parameter int NUM_SECTORS = 64,
  parameter int SECTOR_SHIFT = 18
) (
  input wire logic clk_in, // Core clock, 125 MHz.
  input wire logic rst_n_in, // Power-on reset, active low.
  input wire logic hw_reset_n_in, // Hardware reset pin, active low.
  input wire logic sck_in, // Link clock.
  input wire logic cs_n_in, // Frame select, active low.
  input wire logic si_in, // Serial data in.
  output logic so_out, // Serial data out.
  output logic so_oe_out, // Serial data out enable.
  input wire logic dummy_phase_in, // DDR dummy cycles in progress.
  output logic [flash_aux_pkg::DATA_LINES-1:0] pattern_io_out, // Training preamble on data lines.
  output logic pattern_oe_out, // Preamble drive enable.
  input wire logic write_enable_in, // Write enable latch.
  input wire logic freeze_in, // Freeze bit of configuration one.
  input wire logic ppb_lock_in, // Protection array lock bit.
  output logic program_error_out, // Program error pulse for status one.
  output logic [NUM_SECTORS-1:0] sector_protect_out, // One per sector, high when protected.
  output logic otp_ecc_off_out // ECC disabled for the chunk last read.
);
  localparam int SW = $clog2(NUM_SECTORS);

  generate
    if (NUM_SECTORS < 2 || SECTOR_SHIFT + SW > 32)
    begin : g_bad
      $error("Sector count or sector size does not fit the address.");
    end
  endgenerate

  typedef struct packed {
    logic [2:0] bit_cnt;
    logic [3:0] byte_cnt;
    logic [7:0] shift;
    logic [7:0] opcode;
    logic [31:0] addr;
    logic [7:0] out_byte;
    logic out_en;
    logic drive;
    logic [1:0] pos;
  } frame_t;

  typedef struct packed {
    logic req_tgl;
    flash_aux_pkg::op_kind_t req_kind;
    logic [31:0] req_addr;
    logic [7:0] req_data;
    logic rsp_s1;
    logic rsp_s2;
    logic rsp_seen;
    logic [7:0] rsp_buf;
  } link_t;

  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic req_seen;
    logic wel_s1;
    logic wel_s2;
    logic frz_s1;
    logic frz_s2;
    logic lock_s1;
    logic lock_s2;
    logic hrst_s1;
    logic hrst_s2;
    logic [NUM_SECTORS-1:0] nonvolatile_sector_protect_bit;
    logic [NUM_SECTORS-1:0] volatile_sector_protect_bit;
    logic [7:0] nvpat;
    logic nvpat_set;
    logic [7:0] vpat;
    logic [flash_aux_pkg::CHUNK_COUNT-1:0] once;
    logic [flash_aux_pkg::CHUNK_COUNT-1:0] ecc_off;
    logic rsp_pend;
    logic rsp_tgl;
    logic perr;
    logic ecc_rd;
    logic [NUM_SECTORS-1:0] protect;
  } core_t;

  frame_t fr_reg, fr_next;
  link_t lk_reg, lk_next;
  core_t core_reg, core_next;
  logic so_reg;
  logic frame_rst_n;
  logic mem_prog;
  logic mem_rd;
  logic [7:0] mem_rdata;
  logic [7:0] rx_byte;
  logic [31:0] addr_full;
  logic [SW-1:0] sect_link;
  logic [SW-1:0] sect_core;
  logic [5:0] chunk_core;
  logic [3:0] alen;

  function automatic logic [3:0] addr_len(input logic [7:0] opc);
    logic [3:0] n;
    n = flash_aux_pkg::ADDR_BYTES_NONE;
    if (opc == flash_aux_pkg::OPC_PERSIST_READ_4B || opc == flash_aux_pkg::OPC_PERSIST_PROGRAM_4B
        || opc == flash_aux_pkg::OPC_DYNAMIC_READ_4B || opc == flash_aux_pkg::OPC_DYNAMIC_WRITE_4B)
    begin
      n = flash_aux_pkg::ADDR_BYTES_4;
    end
    else if (opc == flash_aux_pkg::OPC_PERSIST_READ || opc == flash_aux_pkg::OPC_PERSIST_PROGRAM
             || opc == flash_aux_pkg::OPC_DYNAMIC_READ || opc == flash_aux_pkg::OPC_DYNAMIC_WRITE
             || opc == flash_aux_pkg::OPC_SECURE_READ || opc == flash_aux_pkg::OPC_SECURE_PROGRAM)
    begin
      n = flash_aux_pkg::ADDR_BYTES_3;
    end
    return n;
  endfunction

  // Select high clears the frame logic, so a cut frame leaves no half byte.
  assign frame_rst_n = rst_n_in & ~cs_n_in;
  assign rx_byte = {fr_reg.shift[6:0], si_in};
  assign alen = addr_len(fr_reg.opcode);
  assign addr_full = {fr_reg.addr[23:0], rx_byte};
  assign sect_link = addr_full[SECTOR_SHIFT +: SW];

  always_comb
  begin
    fr_next = fr_reg;
    lk_next = lk_reg;
    fr_next.shift = rx_byte;
    fr_next.bit_cnt = fr_reg.bit_cnt + 3'h1;
    fr_next.drive = dummy_phase_in;
    fr_next.pos = fr_reg.drive ? fr_reg.pos + 2'h1 : 2'h0;
    lk_next.rsp_s1 = core_reg.rsp_tgl;
    lk_next.rsp_s2 = lk_reg.rsp_s1;
    if (lk_reg.rsp_s2 != lk_reg.rsp_seen)
    begin
      lk_next.rsp_seen = lk_reg.rsp_s2;
      lk_next.rsp_buf = mem_rdata;
    end
    if (fr_reg.bit_cnt == 3'h7)
    begin
      if (fr_reg.byte_cnt != flash_aux_pkg::BYTE_COUNT_MAX)
      begin
        fr_next.byte_cnt = fr_reg.byte_cnt + 4'h1;
      end
      if (fr_reg.byte_cnt == 4'h0)
      begin
        fr_next.opcode = rx_byte;
        if (rx_byte == flash_aux_pkg::OPC_PERSIST_ERASE)
        begin
          lk_next.req_tgl = ~lk_reg.req_tgl;
          lk_next.req_kind = flash_aux_pkg::OP_PERSIST_ERASE;
        end
        else if (rx_byte == flash_aux_pkg::OPC_PATTERN_READ)
        begin
          fr_next.out_byte = core_reg.vpat;
          fr_next.out_en = 1'b1;
        end
      end
      else if (fr_reg.byte_cnt <= alen)
      begin
        fr_next.addr = addr_full;
        if (fr_reg.byte_cnt == alen)
        begin
          unique case (fr_reg.opcode)
            flash_aux_pkg::OPC_PERSIST_READ, flash_aux_pkg::OPC_PERSIST_READ_4B:
            begin
              fr_next.out_byte = core_reg.nonvolatile_sector_protect_bit[sect_link] ? flash_aux_pkg::BYTE_UNPROTECTED
                                                         : flash_aux_pkg::BYTE_PROTECTED;
              fr_next.out_en = 1'b1;
            end
            flash_aux_pkg::OPC_DYNAMIC_READ, flash_aux_pkg::OPC_DYNAMIC_READ_4B:
            begin
              fr_next.out_byte = core_reg.volatile_sector_protect_bit[sect_link] ? flash_aux_pkg::BYTE_UNPROTECTED
                                                         : flash_aux_pkg::BYTE_PROTECTED;
              fr_next.out_en = 1'b1;
            end
            flash_aux_pkg::OPC_PERSIST_PROGRAM, flash_aux_pkg::OPC_PERSIST_PROGRAM_4B:
            begin
              lk_next.req_tgl = ~lk_reg.req_tgl;
              lk_next.req_kind = flash_aux_pkg::OP_PERSIST_PROGRAM;
              lk_next.req_addr = addr_full;
            end
            flash_aux_pkg::OPC_SECURE_READ:
            begin
              // The dummy byte hides the crossing delay of the first fetch.
              lk_next.req_tgl = ~lk_reg.req_tgl;
              lk_next.req_kind = flash_aux_pkg::OP_SECURE_READ;
              lk_next.req_addr = addr_full;
            end
            default:
            begin
            end
          endcase
        end
      end
      else
      begin
        unique case (fr_reg.opcode)
          flash_aux_pkg::OPC_DYNAMIC_WRITE, flash_aux_pkg::OPC_DYNAMIC_WRITE_4B:
          begin
            if (fr_reg.byte_cnt == alen + 4'h1)
            begin
              lk_next.req_tgl = ~lk_reg.req_tgl;
              lk_next.req_kind = flash_aux_pkg::OP_DYNAMIC_WRITE;
              lk_next.req_addr = fr_reg.addr;
              lk_next.req_data = rx_byte;
            end
          end
          flash_aux_pkg::OPC_PATTERN_PROGRAM, flash_aux_pkg::OPC_PATTERN_WRITE:
          begin
            if (fr_reg.byte_cnt == 4'h1)
            begin
              lk_next.req_tgl = ~lk_reg.req_tgl;
              lk_next.req_kind = (fr_reg.opcode == flash_aux_pkg::OPC_PATTERN_PROGRAM)
                                 ? flash_aux_pkg::OP_PATTERN_PROGRAM : flash_aux_pkg::OP_PATTERN_WRITE;
              lk_next.req_data = rx_byte;
            end
          end
          flash_aux_pkg::OPC_SECURE_PROGRAM:
          begin
            lk_next.req_tgl = ~lk_reg.req_tgl;
            lk_next.req_kind = flash_aux_pkg::OP_SECURE_PROGRAM;
            lk_next.req_addr = fr_reg.addr;
            lk_next.req_data = rx_byte;
            fr_next.addr = fr_reg.addr + 32'h1;
          end
          flash_aux_pkg::OPC_SECURE_READ:
          begin
            fr_next.out_byte = lk_next.rsp_buf;
            fr_next.out_en = 1'b1;
            lk_next.req_tgl = ~lk_reg.req_tgl;
            lk_next.req_kind = flash_aux_pkg::OP_SECURE_READ;
            lk_next.req_addr = fr_reg.addr + 32'h1;
            fr_next.addr = fr_reg.addr + 32'h1;
          end
          default:
          begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge sck_in or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      fr_reg <= '0;
    end
    else
    begin
      fr_reg <= fr_next;
    end
  end

  // Toggles keep their parity across frames, so only power-on clears them.
  always_ff @(posedge sck_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      lk_reg <= '0;
    end
    else
    begin
      lk_reg <= lk_next;
    end
  end

  always_ff @(negedge sck_in or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      so_reg <= 1'b0;
    end
    else
    begin
      so_reg <= fr_reg.out_byte[~fr_reg.bit_cnt];
    end
  end

  assign so_out = so_reg;
  assign so_oe_out = fr_reg.out_en;
  // Both edges carry a bit; the link clock level picks which one is shown.
  assign pattern_io_out = {flash_aux_pkg::DATA_LINES{core_reg.vpat[{~fr_reg.pos, sck_in}]}};
  assign pattern_oe_out = fr_reg.drive && (core_reg.vpat != flash_aux_pkg::PATTERN_RESET);

  assign sect_core = lk_reg.req_addr[SECTOR_SHIFT +: SW];
  assign chunk_core = lk_reg.req_addr[flash_aux_pkg::CHUNK_SHIFT +: 6];

  always_comb
  begin
    core_next = core_reg;
    mem_prog = 1'b0;
    mem_rd = 1'b0;
    core_next.req_s1 = lk_reg.req_tgl;
    core_next.req_s2 = core_reg.req_s1;
    core_next.wel_s1 = write_enable_in;
    core_next.wel_s2 = core_reg.wel_s1;
    core_next.frz_s1 = freeze_in;
    core_next.frz_s2 = core_reg.frz_s1;
    core_next.lock_s1 = ppb_lock_in;
    core_next.lock_s2 = core_reg.lock_s1;
    core_next.hrst_s1 = hw_reset_n_in;
    core_next.hrst_s2 = core_reg.hrst_s1;
    core_next.perr = 1'b0;
    core_next.rsp_pend = 1'b0;
    if (core_reg.rsp_pend)
    begin
      core_next.rsp_tgl = ~core_reg.rsp_tgl;
    end
    if (!core_reg.hrst_s2)
    begin
      core_next.volatile_sector_protect_bit = '1;
      core_next.vpat = core_reg.nvpat;
    end
    else if (core_reg.req_s2 != core_reg.req_seen)
    begin
      core_next.req_seen = core_reg.req_s2;
      unique case (lk_reg.req_kind)
        flash_aux_pkg::OP_PERSIST_PROGRAM:
        begin
          if (core_reg.wel_s2)
          begin
            if (core_reg.lock_s2)
            begin
              core_next.nonvolatile_sector_protect_bit[sect_core] = 1'b0;
            end
            else
            begin
              core_next.perr = 1'b1;
            end
          end
        end
        flash_aux_pkg::OP_PERSIST_ERASE:
        begin
          if (core_reg.wel_s2)
          begin
            if (core_reg.lock_s2)
            begin
              core_next.nonvolatile_sector_protect_bit = '1;
            end
            else
            begin
              core_next.perr = 1'b1;
            end
          end
        end
        flash_aux_pkg::OP_DYNAMIC_WRITE:
        begin
          if (core_reg.wel_s2)
          begin
            core_next.volatile_sector_protect_bit[sect_core] = (lk_reg.req_data == flash_aux_pkg::BYTE_UNPROTECTED);
          end
        end
        flash_aux_pkg::OP_PATTERN_PROGRAM:
        begin
          if (core_reg.wel_s2)
          begin
            if (core_reg.nvpat_set)
            begin
              core_next.perr = 1'b1;
            end
            else
            begin
              core_next.nvpat = lk_reg.req_data;
              core_next.nvpat_set = 1'b1;
              core_next.vpat = lk_reg.req_data;
            end
          end
        end
        flash_aux_pkg::OP_PATTERN_WRITE:
        begin
          core_next.vpat = lk_reg.req_data;
        end
        flash_aux_pkg::OP_SECURE_PROGRAM:
        begin
          // Only freeze guards this region; sector protection is not consulted.
          if (core_reg.wel_s2 && lk_reg.req_addr[31:flash_aux_pkg::SECURE_ADDR_W] == '0)
          begin
            if (core_reg.frz_s2)
            begin
              core_next.perr = 1'b1;
            end
            else
            begin
              mem_prog = 1'b1;
              if (core_reg.once[chunk_core])
              begin
                core_next.ecc_off[chunk_core] = 1'b1;
              end
              else
              begin
                core_next.once[chunk_core] = 1'b1;
              end
            end
          end
        end
        flash_aux_pkg::OP_SECURE_READ:
        begin
          mem_rd = 1'b1;
          core_next.rsp_pend = 1'b1;
          core_next.ecc_rd = core_reg.ecc_off[chunk_core];
        end
      endcase
    end
    core_next.protect = ~(core_next.nonvolatile_sector_protect_bit & core_next.volatile_sector_protect_bit);
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      core_reg <= '0;
      core_reg.nonvolatile_sector_protect_bit <= '1;
      core_reg.volatile_sector_protect_bit <= '1;
      core_reg.nvpat <= flash_aux_pkg::PATTERN_RESET;
      core_reg.vpat <= flash_aux_pkg::PATTERN_RESET;
      core_reg.once <= flash_aux_pkg::CHUNK_FACTORY_PROGRAMMED;
      core_reg.hrst_s1 <= 1'b1;
      core_reg.hrst_s2 <= 1'b1;
    end
    else
    begin
      core_reg <= core_next;
    end
  end

  assign program_error_out = core_reg.perr;
  assign sector_protect_out = core_reg.protect;
  assign otp_ecc_off_out = core_reg.ecc_rd;

  secure_region_mem #(
    .DEPTH(flash_aux_pkg::SECURE_BYTES),
    .ADDR_W(flash_aux_pkg::SECURE_ADDR_W)
  ) u_mem (
    .clk_in(clk_in),
    .prog_in(mem_prog),
    .prog_addr_in(lk_reg.req_addr[flash_aux_pkg::SECURE_ADDR_W-1:0]),
    .prog_data_in(lk_reg.req_data),
    .rd_in(mem_rd),
    .rd_addr_in(lk_reg.req_addr[flash_aux_pkg::SECURE_ADDR_W-1:0]),
    .rd_data_out(mem_rdata)
  );
endmodule

// ===== tb/flash_protect_otp_training_chk.sv
// Purpose: Port checks for the block.
// Assumes: Link events never fall on a core clock edge.
// Notes: Bound into the block.
`timescale 1ns/1ns
module flash_protect_otp_training_chk (
  input wire logic clk_in, // Core clock.
  input wire logic rst_n_in, // Reset.
  input wire logic sck_in, // Link clock.
  input wire logic cs_n_in, // Frame select.
  input wire logic so_oe_out, // Read drive.
  input wire logic dummy_phase_in, // Dummy flag.
  input wire logic [flash_aux_pkg::DATA_LINES-1:0] pattern_io_out, // Preamble.
  input wire logic pattern_oe_out, // Preamble drive.
  input wire logic write_enable_in, // Write enable.
  input wire logic program_error_out, // Error pulse.
  input wire logic otp_ecc_off_out // Chunk ECC state.
);
  // Saturating count of core cycles since a frame; effects must land near one.
  logic [4:0] idle_reg;
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      idle_reg <= 5'h1f;
    else if (!cs_n_in)
      idle_reg <= 5'h00;
    else if (idle_reg != 5'h1f)
      idle_reg <= idle_reg + 5'h01;
  end
  sequence err_pulse;
    program_error_out ##1 !program_error_out;
  endsequence
  a_error_one_pulse:
    assert property (@(posedge clk_in) disable iff (!rst_n_in) $rose(program_error_out) |-> err_pulse)
    else $error("error pulse too long");
  a_error_near_frame:
    assert property (@(posedge clk_in) disable iff (!rst_n_in) program_error_out |-> idle_reg < 5'h0c)
    else $error("error without frame");
  a_error_needs_wen:
    assert property (@(posedge clk_in) disable iff (!rst_n_in) program_error_out |-> write_enable_in)
    else $error("error without write enable");
  a_reset_clear:
    assert property (@(posedge clk_in) disable iff (!rst_n_in) $rose(rst_n_in) |->
      !program_error_out && !otp_ecc_off_out && !so_oe_out) else $error("reset state");
  a_idle_no_drive:
    assert property (@(posedge clk_in) disable iff (!rst_n_in) cs_n_in |-> !so_oe_out) else $error("idle drive");
  a_idle_no_pattern:
    assert property (@(posedge clk_in) disable iff (!rst_n_in) cs_n_in |-> !pattern_oe_out) else $error("idle pattern");
  a_pattern_same_lines:
    assert property (@(posedge clk_in) disable iff (!rst_n_in) pattern_oe_out |->
      pattern_io_out == {flash_aux_pkg::DATA_LINES{pattern_io_out[0]}}) else $error("lines differ");
  a_pattern_needs_dummy:
    assert property (@(posedge sck_in) disable iff (!rst_n_in) pattern_oe_out |-> $past(dummy_phase_in))
    else $error("pattern outside dummy");
  a_ecc_near_read:
    assert property (@(posedge clk_in) disable iff (!rst_n_in) !$stable(otp_ecc_off_out) |-> idle_reg < 5'h0c)
    else $error("ecc state moved idle");
endmodule
bind flash_protect_otp_training flash_protect_otp_training_chk chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .sck_in(sck_in), .cs_n_in(cs_n_in), .so_oe_out(so_oe_out), .dummy_phase_in(dummy_phase_in),
  .pattern_io_out(pattern_io_out), .pattern_oe_out(pattern_oe_out), .write_enable_in(write_enable_in),
  .program_error_out(program_error_out), .otp_ecc_off_out(otp_ecc_off_out));

// ===== tb/flash_host_model.sv
// Purpose: Host controller issuing serial frames.
// Assumes: Callers enter on a core clock edge, so link events avoid it.
// Notes: The link clock stays parked low between frames.
`timescale 1ns/1ns
module flash_host_model (
  output logic sck_out, // Link clock.
  output logic cs_n_out, // Frame select.
  output logic si_out, // Serial out.
  output logic dummy_out, // Dummy flag.
  input wire logic so_in, // Serial in.
  input wire logic [flash_aux_pkg::DATA_LINES-1:0] pattern_io_in, // Preamble.
  input wire logic pattern_oe_in // Preamble drive.
);
  initial
  begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b1;
    dummy_out = 1'b0;
  end
  task automatic xbyte(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--)
    begin
      si_out = b[i];
      #32 sck_out = 1'b1;
      r = {r[6:0], so_in};
      #32 sck_out = 1'b0;
    end
  endtask
  // Opcode, address, data, dummy bytes; then one read byte if no data.
  task automatic cmd(input logic [7:0] op, input int na, input logic [31:0] a, input int nw,
    input logic [15:0] wd, input int nd, output logic [7:0] rd);
    logic [7:0] r;
    #3 cs_n_out = 1'b0;
    xbyte(op, r);
    for (int i = na - 1; i >= 0; i--)
      xbyte(a[8*i +: 8], r);
    for (int i = 0; i < nw; i++)
      xbyte(wd[15-8*i -: 8], r);
    for (int i = 0; i < nd; i++)
      xbyte(8'h00, r);
    if (nw == 0)
      xbyte(8'h00, rd);
    #3 cs_n_out = 1'b1;
    si_out = ~si_out;
    #114;
  endtask
  task automatic ddr(output logic [7:0] seen, output int n);
    logic [7:0] r;
    n = 0;
    seen = 8'h00;
    #3 cs_n_out = 1'b0;
    xbyte(8'h00, r);
    dummy_out = 1'b1;
    for (int k = 0; k < 16; k++)
    begin
      #16;
      if (pattern_oe_in === 1'b1 && n < 8)
      begin
        seen = {seen[6:0], pattern_io_in[0]};
        n++;
      end
      #16 sck_out = ~sck_out;
    end
    dummy_out = 1'b0;
    #3 cs_n_out = 1'b1;
    #114;
  endtask
endmodule

// ===== tb/flash_protect_otp_training_test.sv
// Purpose: Self-checking bench for the block.
// Assumes: Status inputs are levels held steady around frames.
// Notes: Sector index is address bits 23 to 18.
`timescale 1ns/1ns
module flash_protect_otp_training_test;
  logic clk_in = 1'b0, rst_n_in = 1'b0, hw_n = 1'b1, we = 1'b1, frz = 1'b0, lk = 1'b1;
  logic sck, cs_n, si, so, so_oe, dum, perr, ecc, pio_oe;
  logic [3:0] pio;
  logic [63:0] prot;
  logic [7:0] rd, b0;
  wire so_w = so_oe ? so : 1'bz;
  int err_total = 0, check_count = 0, perr_n = 0, n, e;
  always #4 clk_in = ~clk_in;
  always @(posedge clk_in) if (perr === 1'b1) perr_n++;
  flash_protect_otp_training dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .hw_reset_n_in(hw_n), .sck_in(sck),
    .cs_n_in(cs_n), .si_in(si), .so_out(so), .so_oe_out(so_oe), .dummy_phase_in(dum), .pattern_io_out(pio),
    .pattern_oe_out(pio_oe), .write_enable_in(we), .freeze_in(frz), .ppb_lock_in(lk),
    .program_error_out(perr), .sector_protect_out(prot), .otp_ecc_off_out(ecc));
  flash_host_model host (.sck_out(sck), .cs_n_out(cs_n), .si_out(si), .dummy_out(dum), .so_in(so_w),
    .pattern_io_in(pio), .pattern_oe_in(pio_oe));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    if (err_total == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Synchronised levels need a few cycles to settle.
  task automatic setin(input logic w, input logic f, input logic l);
    @(negedge clk_in);
    we <= w;
    frz <= f;
    lk <= l;
    repeat (4) @(negedge clk_in);
  endtask
  task automatic c(input logic [7:0] op, input int na = 0, input logic [31:0] a = 32'h0, input int nw = 0,
    input logic [15:0] wd = 16'h0, input int nd = 0);
    host.cmd(op, na, a, nw, wd, nd, rd);
  endtask
  task automatic t_reset;
    c(8'hfc, 3, 32'h0);
    chk(rd, 8'hff);
    c(8'he2, 4, 32'h0014_0000);
    chk(rd, 8'hff);
    c(8'he0, 4, 32'h0014_0000);
    chk(rd, 8'hff);
    c(8'h41);
    chk(rd, 8'h00);
    chk(prot, 64'h0);
  endtask
  task automatic t_dyn;
    setin(1'b0, 1'b0, 1'b1);
    c(8'hfb, 3, 32'h0c_0000, 1);
    c(8'hfa, 3, 32'h0c_0000);
    chk(rd, 8'hff);
    setin(1'b1, 1'b0, 1'b1);
    c(8'hfb, 3, 32'h0c_0000, 1);
    c(8'hfa, 3, 32'h0c_0000);
    chk(rd, 8'h00);
    chk(prot, 64'h8);
    c(8'he1, 4, 32'h000c_0000, 1, 16'hff00);
    c(8'hfa, 3, 32'h0c_0000);
    chk(rd, 8'hff);
    chk(prot, 64'h0);
  endtask
  task automatic t_ppb;
    setin(1'b1, 1'b0, 1'b0);
    e = perr_n;
    c(8'hfd, 3, 32'h1c_0000);
    chk(perr_n, e + 1);
    c(8'hfc, 3, 32'h1c_0000);
    chk(rd, 8'hff);
    setin(1'b1, 1'b0, 1'b1);
    c(8'he3, 4, 32'h001c_0000);
    c(8'hfc, 3, 32'h1c_0000);
    chk(rd, 8'h00);
    chk(prot, 64'h80);
    c(8'he4);
    c(8'hfc, 3, 32'h1c_0000);
    chk(rd, 8'hff);
    chk(prot, 64'h0);
  endtask
  task automatic t_pat;
    c(8'h4a, 0, 32'h0, 1, 16'h5a00);
    c(8'h41);
    chk(rd, 8'h5a);
    host.ddr(rd, n);
    chk({rd, 32'(n)}, {8'h5a, 32'd8});
    @(negedge clk_in);
    hw_n <= 1'b0;
    repeat (5) @(negedge clk_in);
    hw_n <= 1'b1;
    repeat (5) @(negedge clk_in);
    c(8'h41);
    chk(rd, 8'h00);
    e = perr_n;
    c(8'h43, 0, 32'h0, 1, 16'ha500);
    c(8'h41);
    chk(rd, 8'ha5);
    c(8'h43, 0, 32'h0, 1, 16'h3c00);
    c(8'h41);
    chk({rd, 32'(perr_n)}, {8'ha5, 32'(e + 1)});
    c(8'h4a, 0, 32'h0, 1);
    host.ddr(rd, n);
    chk(n, 0);
  endtask
  task automatic t_otp;
    setin(1'b1, 1'b0, 1'b0);
    e = perr_n;
    c(8'h4b, 3, 32'h0, 0, 16'h0, 1);
    b0 = rd;
    c(8'h42, 3, 32'h3fe, 2, 16'h1234);
    c(8'h4b, 3, 32'h3fe, 0, 16'h0, 1);
    chk({rd, ecc}, {8'h12, 1'b0});
    c(8'h4b, 3, 32'h3ff, 0, 16'h0, 1);
    chk({rd, 32'(perr_n)}, {8'h34, 32'(e)});
    c(8'h42, 3, 32'h3f0, 1, 16'h7700);
    c(8'h4b, 3, 32'h3f0, 0, 16'h0, 1);
    chk({rd, ecc}, {8'h77, 1'b1});
    c(8'h42, 3, 32'h400, 1);
    c(8'h4b, 3, 32'h0, 0, 16'h0, 1);
    chk({rd, 32'(perr_n)}, {b0, 32'(e)});
    setin(1'b1, 1'b1, 1'b0);
    c(8'h42, 3, 32'h20, 1);
    c(8'h4b, 3, 32'h20, 0, 16'h0, 1);
    chk({rd, 32'(perr_n)}, {8'hff, 32'(e + 1)});
  endtask
  initial
  begin
    repeat (6) @(negedge clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(negedge clk_in);
    t_reset;
    t_dyn;
    t_ppb;
    t_pat;
    t_otp;
    wrap_up;
  end
  initial
  begin
    #400000;
    err_total++;
    wrap_up;
  end
endmodule
